// *** design/tsseq_defs.vh ***
`ifndef TSSEQ_DEFS_VH
`define TSSEQ_DEFS_VH

// register word indices (byte address = index * 4)
`define TSSEQ_IDX_RUN 6'h00
`define TSSEQ_IDX_BTEL 6'h01
`define TSSEQ_IDX_BTEH 6'h02
`define TSSEQ_IDX_HOLD 6'h03
`define TSSEQ_IDX_T0LIM 6'h04
`define TSSEQ_IDX_T1LIM 6'h05
`define TSSEQ_IDX_SDLIM 6'h06
`define TSSEQ_IDX_C0LIM 6'h07
`define TSSEQ_IDX_C1LIM 6'h08
`define TSSEQ_IDX_ADJ 6'h09
`define TSSEQ_IDX_LIT 6'h0a
`define TSSEQ_IDX_QPTR 6'h0b
`define TSSEQ_IDX_STAT 6'h0c
`define TSSEQ_IDX_QUE0 6'h10
`define TSSEQ_IDX_QUE15 6'h1f

// run register fields
`define TSSEQ_RUN_START 0
`define TSSEQ_RUN_SWT 1

// opcodes (upper nibble of a step byte)
`define TSSEQ_OP_CTRL 4'h0
`define TSSEQ_OP_ADD 4'h1
`define TSSEQ_OP_WHI 4'h4
`define TSSEQ_OP_WLO 4'h5
`define TSSEQ_OP_IRQ 4'h7

// control operands
`define TSSEQ_CT_SDOFF 4'h2
`define TSSEQ_CT_SDON 4'h6
`define TSSEQ_CT_T0 4'h8
`define TSSEQ_CT_T1 4'h9
`define TSSEQ_CT_SWLVL 4'ha
`define TSSEQ_CT_SWEDG 4'hb
`define TSSEQ_CT_BCAST 4'hf

`define TSSEQ_RST16 16'h0000

`endif

// *** design/tsseq_top.v ***
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`include "tsseq_defs.vh"

module tsseq_top #(
    parameter NTRIG_IN = 16
)(
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // avalon-mm slave
    input wire [5:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // trigger inputs from other peripherals
    input wire [NTRIG_IN-1:0] TRIG_IN,
    // sequencer outputs; TRIG_OUT, IRQ_OUT and CONV_START are one-cycle pulses, CONV_CHAN and BUSY are levels
    output reg [31:0] TRIG_OUT,
    output reg [7:0] IRQ_OUT,
    output reg [4:0] CONV_CHAN,
    output reg CONV_START,
    output reg BUSY
);

localparam ST_IDLE = 3'h0;
localparam ST_FETCH = 3'h1;
localparam ST_EXEC = 3'h2;
localparam ST_WAIT = 3'h3;
localparam ST_DELAY = 3'h4;

////////////////////////////////////////////////////////////////////////
// registers
reg [15:0] bte_lo, bte_hi, hold_value, timer0_limit, timer1_limit;
reg [15:0] step_delay_limit, loop_counter0_limit, loop_counter1_limit;
reg [15:0] adjust_value, literal_zero;
reg [4:0] queue_pointer;
reg [15:0] step_queue_pair [0:15];
reg run, swt, sd_en;
reg [15:0] loop_counter0, loop_counter1, tmr, sd_cnt;
reg [2:0] state;
reg [7:0] step;
reg [1:0] wait_kind;
reg [3:0] wait_sel;
reg jumped;
reg sw_prev;

// inputs come from outside this clock: three-stage synchroniser
reg [NTRIG_IN-1:0] s1, s2, s3;
// a line changes only once stages two and three agree; a line that idles
// high shows one false rise a few clocks after reset, before any step runs
reg [NTRIG_IN-1:0] trig_st, trig_prev;
always @(posedge CLK)
begin
    if (!RSTN)
    begin
        s1 <= {NTRIG_IN{1'b0}};
        s2 <= {NTRIG_IN{1'b0}};
        s3 <= {NTRIG_IN{1'b0}};
        trig_st <= {NTRIG_IN{1'b0}};
        trig_prev <= {NTRIG_IN{1'b0}};
    end
    else
    begin
        s1 <= TRIG_IN;
        s2 <= s1;
        s3 <= s2;
        trig_st <= (s2 & s3) | (trig_st & (s2 | s3));
        trig_prev <= trig_st;
    end
end
wire sel_now = trig_st[wait_sel];
wire sel_old = trig_prev[wait_sel];

////////////////////////////////////////////////////////////////////////
// bus decode
wire acc = AVS_READ | AVS_WRITE;
// write lock
// writes land at the edge that completes the transfer
wire wr = AVS_WRITE & ~AVS_WAITREQUEST & ~run;
wire wr_any = AVS_WRITE & ~AVS_WAITREQUEST;
wire [15:0] wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
wire is_que = AVS_ADDRESS[5:4] == 2'b01;

function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
        merge = (old & ~m) | (nw & m);
    end
endfunction

wire [3:0] op = step[7:4];
wire [3:0] opd = step[3:0];
wire [4:0] tgt = {step[4], step[3:0]};

// target register update selector for add/copy
wire do_add = state == ST_EXEC && op == `TSSEQ_OP_ADD && !opd[3];
wire do_cpy = state == ST_EXEC && op == `TSSEQ_OP_ADD && opd[3];
wire [15:0] src = do_add ? adjust_value : hold_value;
wire [2:0] tsel = opd[2:0];

function [15:0] upd;
    input [15:0] cur;
    input [2:0] idx;
    begin
        if (do_add && tsel == idx)
            upd = cur + src;
        else if (do_cpy && tsel == idx)
            upd = src;
        else
            upd = cur;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// bus answer: one wait cycle, then waitrequest low
always @(posedge CLK)
begin
    if (!RSTN)
    begin
        AVS_WAITREQUEST <= 1'b1;
        AVS_READDATA <= 32'h00000000;
    end
    else
    begin
        AVS_WAITREQUEST <= ~(acc & AVS_WAITREQUEST);
        if (AVS_READ & AVS_WAITREQUEST)
        begin
            if (is_que)
                AVS_READDATA <= {16'h0000, step_queue_pair[AVS_ADDRESS[3:0]]};
            else
                case (AVS_ADDRESS)
                `TSSEQ_IDX_RUN: AVS_READDATA <= {30'h0, swt, run};
                `TSSEQ_IDX_BTEL: AVS_READDATA <= {16'h0000, bte_lo};
                `TSSEQ_IDX_BTEH: AVS_READDATA <= {16'h0000, bte_hi};
                `TSSEQ_IDX_HOLD: AVS_READDATA <= {16'h0000, hold_value};
                `TSSEQ_IDX_T0LIM: AVS_READDATA <= {16'h0000, timer0_limit};
                `TSSEQ_IDX_T1LIM: AVS_READDATA <= {16'h0000, timer1_limit};
                `TSSEQ_IDX_SDLIM:
                    AVS_READDATA <= {16'h0000, step_delay_limit};
                `TSSEQ_IDX_C0LIM:
                    AVS_READDATA <= {16'h0000, loop_counter0_limit};
                `TSSEQ_IDX_C1LIM:
                    AVS_READDATA <= {16'h0000, loop_counter1_limit};
                `TSSEQ_IDX_ADJ: AVS_READDATA <= {16'h0000, adjust_value};
                `TSSEQ_IDX_LIT: AVS_READDATA <= {16'h0000, literal_zero};
                `TSSEQ_IDX_QPTR: AVS_READDATA <= {27'h0, queue_pointer};
                `TSSEQ_IDX_STAT: AVS_READDATA <= {28'h0, sd_en, BUSY,
                                                  state[1:0]};
                default: AVS_READDATA <= 32'h00000000;
                endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// queue storage; software writes only while stopped
// sixteen pair entries
genvar g;
generate
    for (g = 0; g < 16; g = g + 1)
    begin : q
        always @(posedge CLK)
        begin
            if (!RSTN)
                step_queue_pair[g] <= `TSSEQ_RST16;
            else if (wr && is_que && AVS_ADDRESS[3:0] == g)
                step_queue_pair[g] <= merge(step_queue_pair[g],
                                            AVS_WRITEDATA[15:0], wmask);
        end
    end
endgenerate

// software registers and target updates by add/copy steps
always @(posedge CLK)
begin
    if (!RSTN)
    begin
        bte_lo <= `TSSEQ_RST16;
        bte_hi <= `TSSEQ_RST16;
        hold_value <= `TSSEQ_RST16;
        timer0_limit <= `TSSEQ_RST16;
        timer1_limit <= `TSSEQ_RST16;
        step_delay_limit <= `TSSEQ_RST16;
        loop_counter0_limit <= `TSSEQ_RST16;
        loop_counter1_limit <= `TSSEQ_RST16;
        adjust_value <= `TSSEQ_RST16;
        literal_zero <= `TSSEQ_RST16;
    end
    else
    begin
        loop_counter0_limit <= upd(loop_counter0_limit, 3'h0);
        loop_counter1_limit <= upd(loop_counter1_limit, 3'h1);
        timer0_limit <= upd(timer0_limit, 3'h2);
        timer1_limit <= upd(timer1_limit, 3'h3);
        step_delay_limit <= upd(step_delay_limit, 3'h4);
        literal_zero <= upd(literal_zero, 3'h5);
        if (wr)
            case (AVS_ADDRESS)
            `TSSEQ_IDX_BTEL: bte_lo <= merge(bte_lo, AVS_WRITEDATA[15:0],
                                             wmask);
            `TSSEQ_IDX_BTEH: bte_hi <= merge(bte_hi, AVS_WRITEDATA[15:0],
                                             wmask);
            `TSSEQ_IDX_HOLD: hold_value <= merge(hold_value,
                                                 AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_T0LIM: timer0_limit <= merge(timer0_limit,
                                                    AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_T1LIM: timer1_limit <= merge(timer1_limit,
                                                    AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_SDLIM: step_delay_limit <= merge(step_delay_limit,
                                                AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_C0LIM: loop_counter0_limit <= merge(
                loop_counter0_limit, AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_C1LIM: loop_counter1_limit <= merge(
                loop_counter1_limit, AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_ADJ: adjust_value <= merge(adjust_value,
                                                  AVS_WRITEDATA[15:0], wmask);
            `TSSEQ_IDX_LIT: literal_zero <= merge(literal_zero,
                                                  AVS_WRITEDATA[15:0], wmask);
            default: ;
            endcase
    end
end

////////////////////////////////////////////////////////////////////////
// sequencer
wire [15:0] cur_pair = step_queue_pair[queue_pointer[4:1]];
wire [4:0] qp_inc = queue_pointer + 5'h01;
wire run_wr = wr_any && AVS_ADDRESS == `TSSEQ_IDX_RUN && AVS_BYTEENABLE[0];
wire c0_done = loop_counter0 == loop_counter0_limit;
wire c1_done = loop_counter1 == loop_counter1_limit;

always @(posedge CLK)
begin
    if (!RSTN)
    begin
        run <= 1'b0;
        swt <= 1'b0;
        sw_prev <= 1'b0;
        sd_en <= 1'b0;
        state <= ST_IDLE;
        step <= 8'h00;
        queue_pointer <= 5'h00;
        loop_counter0 <= `TSSEQ_RST16;
        loop_counter1 <= `TSSEQ_RST16;
        tmr <= `TSSEQ_RST16;
        sd_cnt <= `TSSEQ_RST16;
        wait_kind <= 2'h0;
        wait_sel <= 4'h0;
        jumped <= 1'b0;
        TRIG_OUT <= 32'h00000000;
        IRQ_OUT <= 8'h00;
        CONV_CHAN <= 5'h00;
        CONV_START <= 1'b0;
        BUSY <= 1'b0;
    end
    else
    begin
        TRIG_OUT <= 32'h00000000;
        IRQ_OUT <= 8'h00;
        CONV_START <= 1'b0;
        BUSY <= run;
        sw_prev <= swt;
        if (run_wr)
        begin
            run <= AVS_WRITEDATA[`TSSEQ_RUN_START];
            swt <= AVS_WRITEDATA[`TSSEQ_RUN_SWT];
        end
        else if (wr && AVS_ADDRESS == `TSSEQ_IDX_QPTR && AVS_BYTEENABLE[0])
            queue_pointer <= AVS_WRITEDATA[4:0];
        if (!run)
            state <= ST_IDLE;
        else
            case (state)
            ST_IDLE: state <= ST_FETCH;
            ST_FETCH:
            begin
                step <= queue_pointer[0] ? cur_pair[15:8] : cur_pair[7:0];
                jumped <= 1'b0;
                tmr <= `TSSEQ_RST16;
                state <= ST_EXEC;
            end
            ST_EXEC:
            begin
                state <= ST_DELAY;
                sd_cnt <= `TSSEQ_RST16;
                casez (op)
                `TSSEQ_OP_CTRL:
                    case (opd)
                    `TSSEQ_CT_SDOFF: sd_en <= 1'b0;
                    `TSSEQ_CT_SDON: sd_en <= 1'b1;
                    `TSSEQ_CT_T0, `TSSEQ_CT_T1:
                    begin
                        wait_kind <= 2'h2;
                        state <= ST_WAIT;
                    end
                    `TSSEQ_CT_SWLVL, `TSSEQ_CT_SWEDG:
                    begin
                        wait_kind <= 2'h3;
                        state <= ST_WAIT;
                    end
                    `TSSEQ_CT_BCAST: TRIG_OUT <= {bte_hi, bte_lo};
                    default: ;
                    endcase
                4'b001?:
                    if (op[1])
                    begin
                        CONV_CHAN <= tgt;
                        CONV_START <= 1'b1;
                    end
                `TSSEQ_OP_WHI, `TSSEQ_OP_WLO:
                begin
                    wait_kind <= {1'b0, op[0]};
                    wait_sel <= opd;
                    state <= ST_WAIT;
                end
                `TSSEQ_OP_IRQ:
                    if (!opd[3])
                        IRQ_OUT[opd[2:0]] <= 1'b1;
                4'b100?: TRIG_OUT[tgt] <= 1'b1;
                4'b101?:
                begin
                    queue_pointer <= tgt;
                    jumped <= 1'b1;
                end
                4'b110?:
                    if (c0_done)
                        loop_counter0 <= `TSSEQ_RST16;
                    else
                    begin
                        loop_counter0 <= loop_counter0 + 16'h0001;
                        queue_pointer <= tgt;
                        jumped <= 1'b1;
                    end
                4'b111?:
                    if (c1_done)
                        loop_counter1 <= `TSSEQ_RST16;
                    else
                    begin
                        loop_counter1 <= loop_counter1 + 16'h0001;
                        queue_pointer <= tgt;
                        jumped <= 1'b1;
                    end
                default: ;
                endcase
            end
            ST_WAIT:
            begin
                tmr <= tmr + 16'h0001;
                sd_cnt <= `TSSEQ_RST16;
                case (wait_kind)
                2'h0: if (sel_now && !sel_old) state <= ST_DELAY;
                2'h1: if (!sel_now && sel_old) state <= ST_DELAY;
                2'h2:
                    // timer matches its limit, counted from zero
                    if (tmr == (opd[0] ? timer1_limit : timer0_limit))
                        state <= ST_DELAY;
                default:
                    if (opd[0] ? (swt && !sw_prev) : swt)
                        state <= ST_DELAY;
                endcase
            end
            ST_DELAY:
            begin
                if (sd_en && sd_cnt != step_delay_limit)
                    sd_cnt <= sd_cnt + 16'h0001;
                else
                begin
                    if (!jumped)
                        queue_pointer <= qp_inc;
                    state <= ST_FETCH;
                end
            end
            default: state <= ST_IDLE;
            endcase
    end
end

endmodule

// *** verification/tsseq_properties.sv ***
module tsseq_chk #(
    parameter NTRIG_IN = 16
)(
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // register bus
    input wire [5:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    // far side
    input wire [NTRIG_IN-1:0] TRIG_IN,
    input wire [31:0] TRIG_OUT,
    input wire [7:0] IRQ_OUT,
    input wire [4:0] CONV_CHAN,
    input wire CONV_START,
    input wire BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////
    chk_bus_answer: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered next cycle");
    chk_wait_single: assert property (
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    chk_idle_wait: assert property (
        !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
        else $error("answer without request");
    chk_rdata_hold: assert property (
        $changed(AVS_READDATA) |-> $past(AVS_READ))
        else $error("read data changed without read");
    chk_upper_zero: assert property (
        AVS_READDATA[31:16] == 16'h0000)
        else $error("upper read data not zero");
    // pulses never merge, so one stray term shows up at once
    chk_trig_pulse: assert property (
        |TRIG_OUT |=> TRIG_OUT == 32'h0000_0000)
        else $error("trigger output longer than one cycle");
    chk_irq_single: assert property (
        $onehot0(IRQ_OUT) and (|IRQ_OUT |=> IRQ_OUT == 8'h00))
        else $error("interrupt pulse malformed");
    chk_conv_chan: assert property (
        $changed(CONV_CHAN) |-> CONV_START ##1 !CONV_START)
        else $error("channel changed without strobe");
    chk_run_busy: assert property (
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h00
        && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0] |-> ##2 BUSY)
        else $error("busy not set after start");
    cover property (CONV_START);
    cover property (|IRQ_OUT);
    cover property (!$onehot0(TRIG_OUT));
endmodule

bind tsseq_top tsseq_chk #(.NTRIG_IN(NTRIG_IN)) chk (.CLK(CLK),
    .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .TRIG_IN(TRIG_IN),
    .TRIG_OUT(TRIG_OUT), .IRQ_OUT(IRQ_OUT), .CONV_CHAN(CONV_CHAN),
    .CONV_START(CONV_START), .BUSY(BUSY));

// *** verification/tsseq_far_side.sv ***
module tsseq_far (
    // sequencer outputs
    input wire logic clk,
    input wire logic [31:0] trig_out,
    input wire logic [7:0] irq,
    input wire logic conv,
    // trigger lines back to the sequencer
    output logic [15:0] trig_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int tcnt [32];
    int icnt [8];
    int conv_n;
    int cyc;
    int tlast [32];

    // line 3 idles high so that a fall can be offered later
    initial
    begin
        trig_in = 16'h0008;
    end

    ////////////////////////////////////////////////////////////////////
    // tally pulses
    always @(posedge clk)
    begin
        cyc++;
        for (int k = 0; k < 32; k++)
        begin
            tcnt[k] += (trig_out[k] === 1'b1);
            if (trig_out[k] === 1'b1)
                tlast[k] = cyc;
        end
        for (int k = 0; k < 8; k++)
            icnt[k] += (irq[k] === 1'b1);
        conv_n += (conv === 1'b1);
    end

    // edges launched just after a clock edge
    task automatic set_line(input int k, input logic v);
        @(posedge clk);
        trig_in[k] <= v;
    endtask
endmodule

// *** verification/tsseq_top_bench.sv ***
module tsseq_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic [5:0] adr;
    logic rd;
    logic wr;
    logic [31:0] wdat;
    logic [3:0] be;
    wire [31:0] rdat;
    wire wreq;
    wire [15:0] trig_in;
    wire [31:0] trig_out;
    wire [7:0] irq;
    wire [4:0] chan;
    wire conv;
    wire busy;
    int failures;
    int checks_done;
    logic [31:0] got;
    logic [31:0] exp_v;
    logic [15:0] cfg [32];
    int texp [32];

    tsseq_top dut (.CLK(clk), .RSTN(rst_n), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .TRIG_IN(trig_in), .TRIG_OUT(trig_out),
        .IRQ_OUT(irq), .CONV_CHAN(chan), .CONV_START(conv), .BUSY(busy));
    tsseq_far far (.clk(clk), .trig_out(trig_out), .irq(irq),
        .conv(conv), .trig_in(trig_in));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // one transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input int a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a[5:0];
        wdat <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50)
        begin
            failures++;
            $display("MISMATCH t=%0t bus timeout", $time);
            print_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n = 1'b0;
        adr = 6'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdat = 32'h0;
        be = 4'hf;
        cfg = '{16'h0000, 16'h0002, 16'h8001, 16'h0002, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h6071, 16'h9385, 16'h2a0f, 16'h423a, 16'h1853, 16'h8210,
            16'hbecb, 16'h008e, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'he08f};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // status at 12 and the gap above it are left out
        for (int i = 1; i < 32; i++)
            if (i < 12 || i > 15)
            begin
                bus(0, i, 0);
                chk(got, 0);
            end
        for (int p = 0; p < 2; p++)
            for (int i = 1; i < 32; i++)
                if (i < 12 || i > 15)
                begin
                    exp_v = p ? cfg[i] : 16'ha5c0 + i;
                    bus(1, i, exp_v);
                    bus(0, i, 0);
                    chk(got, exp_v & (i == 11 ? 31 : 32'hffff));
                end
        bus(1, 13, 32'hffff);
        bus(0, 13, 0);
        chk(got, 0);
        $display("test registers done");
        bus(1, 0, 1);
        repeat (60) @(posedge clk);
        chk(busy, 1);
        chk(far.conv_n, 2);
        chk(chan, 26);
        chk(far.tcnt[2], 0);
        far.set_line(2, 1'b1);
        repeat (40) @(posedge clk);
        chk(far.tcnt[2], 0);
        bus(1, 3, 32'h5555);
        far.set_line(3, 1'b0);
        repeat (300) @(posedge clk);
        bus(1, 0, 0);
        texp = '{default: 0};
        texp[5] = 2;
        texp[19] = 2;
        texp[31] = 2;
        texp[16] = 2;
        texp[1] = 2;
        texp[2] = 4;
        texp[15] = 1;
        for (int i = 0; i < 32; i++)
            chk(far.tcnt[i], texp[i]);
        for (int i = 0; i < 8; i++)
            chk(far.icnt[i], i == 1 ? 2 : 0);
        chk(far.conv_n, 4);
        bus(0, 11, 0);
        chk(got, 7);
        bus(0, 7, 0);
        chk(got, 3);
        bus(0, 3, 0);
        chk(got, 2);
        $display("test sequence done");
        // step delay 4, timer0 limit 5, step 6 jumps to itself
        bus(1, 6, 4);
        bus(1, 4, 5);
        bus(1, 11, 0);
        bus(1, 16, 32'h8006);
        bus(1, 17, 32'h0881);
        bus(1, 18, 32'h0282);
        bus(1, 19, 32'h00a6);
        bus(1, 0, 1);
        repeat (120) @(posedge clk);
        bus(1, 0, 0);
        chk(far.tcnt[0], 1);
        chk(far.tlast[1] - far.tlast[0], 3 + 4);
        chk(far.tlast[2] - far.tlast[1], 7 + 2 * 4 + 5);
        // step delay switched off again, sequencer idle
        bus(0, 12, 0);
        chk(got, 0);
        $display("test timing done");
        print_verdict();
    end
endmodule
